// file: design/adc_port_map.svh
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH
// ----------------------------------------------------------------
// Codes, counts and positions
// ----------------------------------------------------------------
`define CONV_CYCLES      44
`define RESULT_BITS      10
`define ADDR_BITS        4
`define FRAME_LONG       16
`define ADDR_LAST_CH     4'hA
`define ADDR_HALF_TEST   4'hB
`define ADDR_ZERO_TEST   4'hC
`define ADDR_FULL_TEST   4'hD
`define CODE_FULL        10'h3FF
`define CODE_HALF        10'h200
`define CODE_ZERO        10'h000
`define EOC_FALL_EDGE    4'hA
`endif

// file: design/adc_port_pkg.sv
package adc_port_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_DONE = 3'b100
	} conv_state_t;

	// Sampled request handed to the converter
	typedef struct packed
	{
		logic [3:0] chan;
		logic [9:0] sample;
	} conv_req_t;
endpackage

// file: design/adc_serial_channel_port.sv
// Behaviour
// - Samples at or beyond either reference clamp to full scale or zero.
// - Ten result bits of the previous conversion shift out MSB first.
// - Shifted-in address selects the next conversion, not the current result.
// - External-clock variant converts in 44 clocks with no done output.
// - Late eleventh rising edge desynchronises the port for that transfer.
// - Address is the first four bits; remaining twelve are ignored.
// - Sixteen-bit frames send result then six zero bits.
// - Sixteen bits may come as one burst or two bursts of eight.
// - Addresses 0 to A select analog inputs zero to ten.
// - Address B gives the half-scale code.
// - Address C gives the all-zero code.
// - Address is taken on the first four rising edges only.
// - Done output falls on tenth falling edge, rises when result ready.
// - Address D gives the full-scale code.
`timescale 1ns/1ps
`include "adc_port_map.svh"
module adc_serial_channel_port
	import adc_port_pkg::*;
#(
	parameter bit EXT_CLOCKED = 1'b0
)
(
	input  wire logic         CORE_CLK,
	input  wire logic         RESET,
	input  wire logic         SHIFT_CLK,
	input  wire logic         CS_N,
	input  wire logic         SER_IN,
	input  wire logic [10:0][9:0] ANALOG_SAMPLE,
	output logic              SER_OUT,
	output logic              SER_OUT_EN_N,
	output logic              CONV_DONE,
	output logic [3:0]        MUX_SELECT,
	output logic              DESYNC
);
	// ------------------------------------------------------------
	// Link domain: shift register on the host shift clock
	// ------------------------------------------------------------
	logic [4:0]  rise_cnt_reg;
	logic [4:0]  fall_cnt_reg;
	logic [3:0]  addr_reg;
	logic [9:0]  shout_reg;
	logic        sout_reg;
	logic        start_tgl_reg;
	logic        rise11_reg;
	logic [9:0]  result_lvl;
	logic [1:0]  cs_sync_l;

	// Host frames start on select; a stopped clock outside frames is safe
	wire cs_act = ~CS_N;

	// Address bits land on the first four rising edges only
	always_ff @(posedge SHIFT_CLK or posedge CS_N)
	begin
		if (CS_N)
		begin
			rise_cnt_reg <= 5'h00;
			addr_reg     <= 4'h0;
			rise11_reg   <= 1'b0;
		end
		else
		begin
			rise_cnt_reg <= rise_cnt_reg + 5'h01;
			if (rise_cnt_reg < 5'(`ADDR_BITS))
				addr_reg <= {addr_reg[2:0], SER_IN};
			// Eleventh rising edge seen; the core judges it against the end
			// of conversion, since this clock may stop at any time
			if (rise_cnt_reg == 5'(`RESULT_BITS))
				rise11_reg <= 1'b1;
		end
	end

	// Result bits change on falling edges, MSB first, zeros after ten
	always_ff @(negedge SHIFT_CLK or posedge CS_N)
	begin
		if (CS_N)
		begin
			fall_cnt_reg  <= 5'h00;
			shout_reg     <= 10'h000;
			sout_reg      <= 1'b0;
		end
		else
		begin
			fall_cnt_reg <= fall_cnt_reg + 5'h01;
			if (fall_cnt_reg == 5'h00)
			begin
				shout_reg <= {result_lvl[8:0], 1'b0};
				sout_reg  <= result_lvl[9];
			end
			else
			begin
				shout_reg <= {shout_reg[8:0], 1'b0};
				sout_reg  <= (fall_cnt_reg < 5'(`RESULT_BITS)) ?
					shout_reg[9] : 1'b0;
			end
		end
	end

	// Tenth falling edge hands over to the converter (level toggle)
	// Limitation: select must stay low three core cycles past this edge,
	// or the address is cleared before the core has taken it
	always_ff @(negedge SHIFT_CLK or posedge RESET)
	begin
		if (RESET)
			start_tgl_reg <= 1'b0;
		else if (cs_act && fall_cnt_reg == 5'(`EOC_FALL_EDGE - 1))
			start_tgl_reg <= ~start_tgl_reg;
	end

	// ------------------------------------------------------------
	// Core domain: conversion sequencer
	// ------------------------------------------------------------
	conv_state_t state_reg;
	conv_state_t state_next;
	logic [2:0]  tgl_sync_reg;
	logic [5:0]  cyc_reg;
	logic [9:0]  result_reg;
	logic [9:0]  hold_reg;
	logic [3:0]  chan_reg;
	logic        done_reg;
	logic [1:0]  frame_sync_reg;
	logic [3:0]  mux_reg;
	logic [1:0]  dsy_sync_reg;
	logic        dsy_reg;
	conv_req_t   req;

	// Saturating code for a channel, tests override the input
	function automatic logic [9:0] code_of(input logic [3:0] ch,
		input logic [10:0][9:0] smp);
		logic [9:0] c;
		c = `CODE_ZERO;
		if (ch <= `ADDR_LAST_CH)
			c = smp[ch];
		else if (ch == `ADDR_HALF_TEST)
			c = `CODE_HALF;
		else if (ch == `ADDR_FULL_TEST)
			c = `CODE_FULL;
		return c;
	endfunction

	wire start_evt = tgl_sync_reg[2] ^ tgl_sync_reg[1];
	wire conv_end  = (state_reg == ST_CONV) &&
		(cyc_reg == 6'(`CONV_CYCLES - 1));
	assign req.chan   = addr_reg;
	assign req.sample = code_of(addr_reg, ANALOG_SAMPLE);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (start_evt) state_next = ST_CONV;
			ST_CONV: if (conv_end) state_next = ST_DONE;
			ST_DONE: if (start_evt) state_next = ST_CONV;
			default: state_next = ST_IDLE;
		endcase
	end

	// Address is stable from fourth rising edge, read after toggle sync
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_reg      <= ST_IDLE;
			tgl_sync_reg   <= 3'h0;
			cyc_reg        <= 6'h00;
			result_reg     <= 10'h000;
			hold_reg       <= 10'h000;
			chan_reg       <= 4'h0;
			done_reg       <= 1'b1;
			frame_sync_reg <= 2'h0;
			mux_reg        <= 4'h0;
			dsy_sync_reg   <= 2'h0;
			dsy_reg        <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			tgl_sync_reg   <= {tgl_sync_reg[1:0], start_tgl_reg};
			frame_sync_reg <= {frame_sync_reg[0], cs_act};
			dsy_sync_reg   <= {dsy_sync_reg[0], rise11_reg};
			// Frame still open at the end with no eleventh edge: lost
			if (!frame_sync_reg[1])
				dsy_reg <= 1'b0;
			else if (conv_end && !dsy_sync_reg[1])
				dsy_reg <= 1'b1;
			if (start_evt)
			begin
				chan_reg <= req.chan;
				mux_reg  <= req.chan;
				// Input is held from the end of sampling, as in a real hold
				hold_reg <= req.sample;
				cyc_reg  <= 6'h00;
				done_reg <= 1'b0;
			end
			else if (state_reg == ST_CONV)
			begin
				cyc_reg <= cyc_reg + 6'h01;
				if (conv_end)
				begin
					result_reg <= hold_reg;
					done_reg   <= 1'b1;
				end
			end
		end
	end

	// Result crosses as a level: it only moves while the host waits
	assign result_lvl = result_reg;
	assign cs_sync_l  = frame_sync_reg;

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic [1:0] sout_sync_reg;
	logic       sout_core_reg;
	logic       oen_core_reg;

	// Link bit passes three flops (two sync, one output): it moves at any phase of the core clock
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sout_sync_reg <= 2'h0;
			sout_core_reg <= 1'b0;
			oen_core_reg  <= 1'b1;
		end
		else
		begin
			sout_sync_reg <= {sout_sync_reg[0], sout_reg};
			sout_core_reg <= sout_sync_reg[1] & ~dsy_reg;
			oen_core_reg  <= ~cs_sync_l[1];
		end
	end
	assign SER_OUT      = sout_core_reg;
	assign SER_OUT_EN_N = oen_core_reg;
	assign CONV_DONE    = EXT_CLOCKED ? 1'b0 : done_reg;
	assign MUX_SELECT   = mux_reg;
	assign DESYNC       = dsy_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_conv_len;
		@(posedge CORE_CLK) disable iff (RESET)
		(state_reg == ST_CONV && $past(state_reg) != ST_CONV)
			|-> ##43 conv_end;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("bad len");

	property p_done_low;
		@(posedge CORE_CLK) disable iff (RESET)
		start_evt |=> !done_reg;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done");

	property p_done_high;
		@(posedge CORE_CLK) disable iff (RESET)
		conv_end |=> done_reg && state_reg == ST_DONE;
	endproperty
	a_done_high: assert property (p_done_high) else $error("dh");

	property p_half;
		@(posedge CORE_CLK) disable iff (RESET)
		conv_end && chan_reg == `ADDR_HALF_TEST |=> result_reg == `CODE_HALF;
	endproperty
	a_half: assert property (p_half) else $error("half");

	property p_zero;
		@(posedge CORE_CLK) disable iff (RESET)
		conv_end && chan_reg == `ADDR_ZERO_TEST |=> result_reg == `CODE_ZERO;
	endproperty
	a_zero: assert property (p_zero) else $error("zero");

	property p_full;
		@(posedge CORE_CLK) disable iff (RESET)
		conv_end && chan_reg == `ADDR_FULL_TEST |=> result_reg == `CODE_FULL;
	endproperty
	a_full: assert property (p_full) else $error("full");

	property p_chan;
		@(posedge CORE_CLK) disable iff (RESET)
		conv_end && chan_reg <= `ADDR_LAST_CH
			|=> result_reg == $past(ANALOG_SAMPLE[chan_reg]);
	endproperty
	a_chan: assert property (p_chan) else $error("chan");

	property p_next;
		@(posedge CORE_CLK) disable iff (RESET)
		start_evt |=> chan_reg == $past(addr_reg);
	endproperty
	a_next: assert property (p_next) else $error("next");

	property p_desync;
		@(posedge CORE_CLK) disable iff (RESET)
		conv_end && frame_sync_reg[1] && !dsy_sync_reg[1] |=> dsy_reg;
	endproperty
	a_desync: assert property (p_desync) else $error("desync");

	property p_idle_oen;
		@(posedge CORE_CLK) disable iff (RESET)
		!frame_sync_reg[1] |=> SER_OUT_EN_N;
	endproperty
	a_idle_oen: assert property (p_idle_oen) else $error("oen");

	c_conv: cover property (@(posedge CORE_CLK) conv_end);
	c_test: cover property (@(posedge CORE_CLK)
		conv_end && chan_reg == `ADDR_HALF_TEST);
	c_dsy: cover property (@(posedge CORE_CLK) dsy_reg);
	c_short: cover property (@(posedge CORE_CLK)
		conv_end && !frame_sync_reg[1]);
endmodule

// file: tb/adc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// Host serial master, link clock 64 ns
// ------------------------------------------
module adc_host_model
(
	output logic            shift_clk,
	output logic            cs_n,
	output logic            ser_in,
	input  wire logic [1:0] ser_out_pair
);
	// Clock idles low and only runs inside frames
	initial
	begin
		shift_clk = 1'b0;
		cs_n = 1'b1;
		ser_in = 1'b0;
	end

	// Data is read mid low phase, 16 ns after the fall, to absorb the core sync lag
	task automatic frame(input logic [15:0] word, input int nclk,
		input int pause_at, input int pause_ns,
		output logic [15:0] rx0, output logic [15:0] rx1);
		rx0 = 16'h0000;
		rx1 = 16'h0000;
		cs_n = 1'b0;
		// Odd lead-in keeps link edges off the core clock edges
		#67;
		for (int i = 0; i < nclk; i++)
		begin
			ser_in = word[15 - i];
			#16;
			shift_clk = 1'b1;
			#32;
			shift_clk = 1'b0;
			#16;
			rx0[15 - i] = ser_out_pair[0];
			rx1[15 - i] = ser_out_pair[1];
			if (i + 1 == pause_at)
				#(pause_ns);
		end
	endtask

	// Released data line flips so a stale value is never seen
	task automatic release_bus();
		cs_n = 1'b1;
		ser_in = ~ser_in;
		#64;
	endtask
endmodule

// file: tb/adc_serial_channel_port_test.sv
`timescale 1ns/1ps
module adc_serial_channel_port_test;
	logic             core_clk;
	logic             reset;
	logic [10:0][9:0] samp;
	wire              shift_clk;
	wire              cs_n;
	wire              ser_in;
	wire  [1:0]       so;
	wire  [1:0]       done;
	wire  [3:0]       mux0;
	wire              desync0;
	wire              oen0;
	int               error_cnt;
	int               n_tests;
	int               seed = 90;
	int               cycles = 0;
	int               exp_q[$];

	// ------------------------------------------
	// Devices under test and host
	// ------------------------------------------
	adc_serial_channel_port uut (.CORE_CLK(core_clk), .RESET(reset),
		.SHIFT_CLK(shift_clk), .CS_N(cs_n), .SER_IN(ser_in),
		.ANALOG_SAMPLE(samp), .SER_OUT(so[0]), .SER_OUT_EN_N(oen0),
		.CONV_DONE(done[0]), .MUX_SELECT(mux0), .DESYNC(desync0));
	adc_serial_channel_port #(.EXT_CLOCKED(1'b1)) uut_ext (
		.CORE_CLK(core_clk), .RESET(reset), .SHIFT_CLK(shift_clk),
		.CS_N(cs_n), .SER_IN(ser_in), .ANALOG_SAMPLE(samp),
		.SER_OUT(so[1]), .SER_OUT_EN_N(), .CONV_DONE(done[1]),
		.MUX_SELECT(), .DESYNC());
	adc_host_model host (.shift_clk(shift_clk), .cs_n(cs_n),
		.ser_in(ser_in), .ser_out_pair(so));

	// Core clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	// ------------------------------------------
	// Model and checks
	// ------------------------------------------
	function automatic int exp_code(int a);
		if (a <= 10)
			return int'(samp[a]);
		if (a == 11)
			return 10'h200;
		if (a == 13)
			return 10'h3FF;
		return 0;
	endfunction

	task automatic chk(logic [15:0] got, logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Inputs change off the core edge, after the conversion is done
	task automatic set_samples();
		@(negedge core_clk);
		for (int k = 0; k < 11; k++)
			samp[k] = 10'($random(seed));
		samp[0] = 10'h3FF;
		samp[1] = 10'h000;
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------
	// Main sequence
	// ------------------------------------------
	initial
	begin
		logic [15:0] w;
		logic [15:0] r0;
		logic [15:0] r1;
		int nclk;
		int k;
		error_cnt = 0;
		n_tests = 0;
		reset = 1'b1;
		samp = '0;
		set_samples();
		repeat (3) @(posedge core_clk);
		@(negedge core_clk) reset = 1'b0;
		// Every code, mixed lengths; first word is reset content
		for (int i = 0; i < 20; i++)
		begin
			w = {4'(i % 16), 12'($random(seed))};
			nclk = (i % 3 == 1) ? 10 : 16;
			host.frame(w, nclk, (i % 3 == 2) ? 8 : 0, 300, r0, r1);
			if (nclk == 10)
				chk({15'h0000, done[0]}, 16'h0000);
			chk({15'h0000, oen0}, 16'h0000);
			chk({15'h0000, desync0}, 16'h0000);
			host.release_bus();
			chk({15'h0000, oen0}, 16'h0001);
			if (i > 0)
			begin
				chk(r0, 16'(exp_q[0] << 6));
				chk(r1, 16'(exp_q[0] << 6));
				void'(exp_q.pop_front());
			end
			exp_q.push_back(exp_code(i % 16));
			k = 0;
			repeat (44) @(negedge core_clk);
			while (done[0] !== 1'b1 && k < 60)
			begin
				@(negedge core_clk);
				k++;
			end
			chk({15'h0000, done[0]}, 16'h0001);
			chk({15'h0000, done[1]}, 16'h0000);
			if (i % 16 <= 10)
				chk({12'h000, mux0}, 16'(i % 16));
			set_samples();
		end
		// Eleventh rising edge held back past the conversion
		host.frame(16'hB000, 16, 10, 400, r0, r1);
		chk(r0, 16'(exp_q[0] << 6));
		chk({15'h0000, desync0}, 16'h0001);
		host.release_bus();
		chk({15'h0000, desync0}, 16'h0000);
		print_verdict();
	end
endmodule
